/* File: rtl/enc_out_pkg.sv */
// Constants, register map and types for the encoder feedback pulse generator.
// Assumes a single 125 MHz system clock and a word-aligned Avalon-MM register bus.
// Operation
// - Polarity bit swaps command pulse rotation sense
// - Settings take effect only after power-on load
// - Setting counts edges; each phase gets quarter
// - Mode 0: setting is edges per revolution
// - Mode 1: resolution divided by setting
// - Mode 2: feedback scaled to command unit
// - Mode 3: resolution times numerator over denominator
// - Gear denominator zero counts as one
// - Fixed encoder resolution per motor revolution
// - Count and divisor span one to 65535 (registers also store zero)
// - Separate A and B phase outputs
package enc_out_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_DIVISOR = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_CMD_NUM = 8'h10;
  localparam logic [7:0] OFS_CMD_DEN = 8'h14;
  localparam logic [7:0] OFS_ACTIVE = 8'h18;
  localparam logic [7:0] OFS_FB_POS = 8'h1c;
  localparam int ACT_DIR_BIT = 0;
  localparam int ACT_MODE_LSB = 1;
  localparam int ACT_PENDING_BIT = 3;
  localparam logic RST_DIR = 1'h0;
  localparam logic [15:0] RST_COUNT = 16'hfa0;
  localparam logic [15:0] RST_DIVISOR = 16'h0001;
  localparam logic [15:0] RST_CMD_GEAR = 16'h0001;
  localparam logic [31:0] ENC_RESOLUTION = 32'h0002_0000;
  localparam logic [31:0] MAX_EDGE_RATE_PPS = 32'h0046_30c0;
  localparam logic signed [35:0] ACC_LIMIT = 36'sh3_0000_0000;
  typedef enum logic [1:0] {
    MODE_PER_REV = 2'h0,
    MODE_DIVIDE = 2'h1,
    MODE_CMD_UNIT = 2'h2,
    MODE_GEAR = 2'h3
  } out_mode_t;
  localparam out_mode_t RST_MODE = MODE_PER_REV;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;
endpackage

/* File: rtl/edge_if.sv */
// Carries quadrature edge requests from the scaler to the phase generator.
// Both ends sit on clk_sys.
`timescale 1ns/1ps
interface edge_if;
  logic tick;
  logic up;
  modport src (output tick, output up);
  modport dst (input tick, input up);
endinterface

/* File: rtl/frac_scaler.sv */
// Fractional rate scaler: numer/denom output edges per motor encoder count.
// Assumes step and stepUp come from logic on clk_sys.
`timescale 1ns/1ps
module frac_scaler
  import enc_out_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic step,
  input wire logic stepUp,
  input wire logic [31:0] numer,
  input wire logic [31:0] denom,
  edge_if.src edges
);
  import enc_out_pkg::*;

  logic signed [35:0] acc_q;
  logic signed [35:0] acc_d;
  logic signed [35:0] numS;
  logic signed [35:0] denS;
  logic emitUp;
  logic emitDn;
  logic tick_q;
  logic up_q;

  assign numS = $signed({4'h0, numer});
  assign denS = $signed({4'h0, denom});

  // One edge per cycle at most; surplus stays in the accumulator and drains later
  always_comb begin
    acc_d = acc_q;
    emitUp = 1'b0;
    emitDn = 1'b0;
    if (acc_q >= denS) begin
      emitUp = 1'b1;
      acc_d = acc_d - denS;
    end else if (acc_q <= -denS) begin
      emitDn = 1'b1;
      acc_d = acc_d + denS;
    end
    // Clamp keeps overdriven ratios from wrapping the sign
    if (step && stepUp && acc_q < ACC_LIMIT) begin
      acc_d = acc_d + numS;
    end else if (step && !stepUp && acc_q > -ACC_LIMIT) begin
      acc_d = acc_d - numS;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 36'sh0;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
      up_q <= 1'b0;
    end else begin
      tick_q <= emitUp || emitDn;
      up_q <= emitUp;
    end
  end

  assign edges.tick = tick_q;
  assign edges.up = up_q;

  a_edge_from_acc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(acc_q) >= $past(denS)) |-> (tick_q && up_q))
    else $error("Accumulator reached divisor without an up edge");
endmodule

/* File: rtl/quad_gen.sv */
// Quadrature A/B generator: one output edge per tick, lead phase from direction.
// Assumes ticks are spaced so the host sees the edge rate it can count.
`timescale 1ns/1ps
module quad_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  edge_if.dst edges,
  output logic outA,
  output logic outB
);
  logic [1:0] phase_q;
  logic [1:0] phaseNext;

  assign phaseNext = edges.up ? phase_q + 2'h1 : phase_q - 2'h1;

  // Gray sequence: A leads B when counting up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      outA <= 1'b0;
      outB <= 1'b0;
    end else if (edges.tick) begin
      phase_q <= phaseNext;
      outA <= phaseNext[1] ^ phaseNext[0];
      outB <= phaseNext[1];
    end
  end

  a_one_edge_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
    edges.tick |=> ((outA != $past(outA)) != (outB != $past(outB))))
    else $error("Tick did not move exactly one phase output");
  a_still_no_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !edges.tick |=> ($stable(outA) && $stable(outB)))
    else $error("Phase output moved without a tick");
endmodule

/* File: rtl/encoder_pulse_output_gen.sv */
// Top of the encoder feedback pulse generator with its Avalon-MM register file.
// Assumes motor step, command pulse and load inputs come from logic on clk_sys.
`timescale 1ns/1ps
module encoder_pulse_output_gen
  import enc_out_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [enc_out_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [enc_out_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [enc_out_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic powerOnLoad,
  input wire logic cmdPulse,
  input wire logic cmdFwd,
  output logic motorCmdStep,
  output logic motorCmdCcw,
  input wire logic motorStep,
  input wire logic motorCcw,
  output logic encOutA,
  output logic encOutB
);
  import enc_out_pkg::*;

  bus_state_t busState_q;
  logic busReq;
  logic wrTake;
  logic [DATA_W-1:0] rdMux;

  // Staged values written by software
  logic dirStage_q;
  logic [15:0] countStage_q;
  logic [15:0] divisorStage_q;
  out_mode_t modeStage_q;
  logic [15:0] cmdNumStage_q;
  logic [15:0] cmdDenStage_q;

  // Values in force since the last power-on load
  logic loadPending_q;
  logic dirActive_q;
  logic [15:0] countActive_q;
  logic [15:0] divisorActive_q;
  out_mode_t modeActive_q;
  logic [15:0] cmdNumActive_q;
  logic [15:0] cmdDenActive_q;

  logic [31:0] numer_q;
  logic [31:0] denom_q;
  logic [31:0] numer_d;
  logic [31:0] denom_d;
  logic [31:0] fbPos_q;
  logic fbUp;

  edge_if edgeBus ();

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  function automatic logic [15:0] atLeastOne(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  // Bus slave: every access answers in the cycle after it is seen
  assign busReq = avs_read || avs_write;
  assign wrTake = avs_write && (busState_q == BUS_ANSWER);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busState_q <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (busState_q)
        BUS_IDLE: begin
          if (busReq) begin
            busState_q <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
          end
        end
        BUS_ANSWER: begin
          busState_q <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          busState_q <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rdMux = '0;
    unique case (avs_address)
      OFS_DIR: rdMux = {31'h0, dirStage_q};
      OFS_COUNT: rdMux = {16'h0, countStage_q};
      OFS_DIVISOR: rdMux = {16'h0, divisorStage_q};
      OFS_MODE: rdMux = {30'h0, modeStage_q};
      OFS_CMD_NUM: rdMux = {16'h0, cmdNumStage_q};
      OFS_CMD_DEN: rdMux = {16'h0, cmdDenStage_q};
      OFS_ACTIVE: rdMux = {28'h0, loadPending_q, modeActive_q, dirActive_q};
      OFS_FB_POS: rdMux = fbPos_q;
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (busState_q == BUS_IDLE && avs_read) begin
      avs_readdata <= rdMux;
    end
  end

  // Any 16-bit value is stored; zero is taken as one where it divides
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirStage_q <= RST_DIR;
      countStage_q <= RST_COUNT;
      divisorStage_q <= RST_DIVISOR;
      modeStage_q <= RST_MODE;
      cmdNumStage_q <= RST_CMD_GEAR;
      cmdDenStage_q <= RST_CMD_GEAR;
    end else if (wrTake) begin
      unique case (avs_address)
        OFS_DIR: begin
          if (avs_byteenable[0]) begin
            dirStage_q <= avs_writedata[0];
          end
        end
        OFS_COUNT: countStage_q <= merge16(countStage_q, avs_writedata, avs_byteenable);
        OFS_DIVISOR: divisorStage_q <= merge16(divisorStage_q, avs_writedata, avs_byteenable);
        OFS_MODE: begin
          if (avs_byteenable[0]) begin
            modeStage_q <= out_mode_t'(avs_writedata[1:0]);
          end
        end
        OFS_CMD_NUM: cmdNumStage_q <= merge16(cmdNumStage_q, avs_writedata, avs_byteenable);
        OFS_CMD_DEN: cmdDenStage_q <= merge16(cmdDenStage_q, avs_writedata, avs_byteenable);
        default: begin
        end
      endcase
    end
  end

  // Load once after reset release, then only on a power-on load pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loadPending_q <= 1'b1;
    end else begin
      loadPending_q <= powerOnLoad;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirActive_q <= RST_DIR;
      countActive_q <= RST_COUNT;
      divisorActive_q <= RST_DIVISOR;
      modeActive_q <= RST_MODE;
      cmdNumActive_q <= RST_CMD_GEAR;
      cmdDenActive_q <= RST_CMD_GEAR;
    end else if (loadPending_q) begin
      dirActive_q <= dirStage_q;
      countActive_q <= countStage_q;
      divisorActive_q <= divisorStage_q;
      modeActive_q <= modeStage_q;
      cmdNumActive_q <= cmdNumStage_q;
      cmdDenActive_q <= cmdDenStage_q;
    end
  end

  // Ratio of output edges to encoder counts; no divider needed
  always_comb begin
    numer_d = {16'h0, countActive_q};
    denom_d = ENC_RESOLUTION;
    unique case (modeActive_q)
      MODE_PER_REV: begin
        numer_d = {16'h0, countActive_q};
        denom_d = ENC_RESOLUTION;
      end
      MODE_DIVIDE: begin
        numer_d = 32'h0000_0001;
        denom_d = {16'h0, atLeastOne(countActive_q)};
      end
      MODE_CMD_UNIT: begin
        numer_d = {16'h0, atLeastOne(cmdDenActive_q)};
        denom_d = {16'h0, atLeastOne(cmdNumActive_q)};
      end
      MODE_GEAR: begin
        numer_d = {16'h0, countActive_q};
        denom_d = {16'h0, atLeastOne(divisorActive_q)};
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      numer_q <= {16'h0, RST_COUNT};
      denom_q <= ENC_RESOLUTION;
    end else begin
      numer_q <= numer_d;
      denom_q <= denom_d;
    end
  end

  // Command pulse direction mapping
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      motorCmdStep <= 1'b0;
      motorCmdCcw <= 1'b0;
    end else begin
      motorCmdStep <= cmdPulse;
      motorCmdCcw <= cmdFwd ^ dirActive_q;
    end
  end

  // Feedback counts up for the rotation that forward commands produce
  assign fbUp = motorCcw ^ dirActive_q;

  frac_scaler u_scaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .step(motorStep),
    .stepUp(fbUp),
    .numer(numer_q),
    .denom(denom_q),
    .edges(edgeBus.src)
  );

  quad_gen u_quad (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .edges(edgeBus.dst),
    .outA(encOutA),
    .outB(encOutB)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fbPos_q <= 32'h0;
    end else if (edgeBus.tick) begin
      fbPos_q <= edgeBus.up ? fbPos_q + 32'h1 : fbPos_q - 32'h1;
    end
  end

  a_dir_mapping: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmdPulse |=> (motorCmdStep && motorCmdCcw == ($past(cmdFwd) ^ $past(dirActive_q))))
    else $error("Command direction mapped wrongly");
  a_hold_active: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !loadPending_q |=> ($stable(dirActive_q) && $stable(countActive_q) && $stable(divisorActive_q)))
    else $error("Active setting changed without a load");
  a_load_active: assert property (@(posedge clk_sys) disable iff (!rst_n)
    loadPending_q |=> (dirActive_q == $past(dirStage_q) && countActive_q == $past(countStage_q)))
    else $error("Load did not copy staged settings");
  a_mode_per_rev: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modeActive_q == MODE_PER_REV |=> (numer_q == {16'h0, $past(countActive_q)} && denom_q == 32'h0002_0000))
    else $error("Per-revolution ratio wrong");
  a_mode_divide: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (modeActive_q == MODE_DIVIDE && countActive_q != 16'h0) |=> (numer_q == 32'h1 && denom_q[15:0] == $past(countActive_q)))
    else $error("Division ratio wrong");
  a_mode_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (modeActive_q == MODE_CMD_UNIT && cmdNumActive_q != 16'h0) |=> (denom_q[15:0] == $past(cmdNumActive_q)))
    else $error("Command unit ratio wrong");
  a_mode_gear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (modeActive_q == MODE_GEAR && divisorActive_q != 16'h0) |=> (numer_q[15:0] == $past(countActive_q) && denom_q[15:0] == $past(divisorActive_q)))
    else $error("Gear ratio wrong");
  a_den_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (modeActive_q == MODE_GEAR && divisorActive_q == 16'h0) |=> denom_q == 32'h1)
    else $error("Zero denominator not taken as one");
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (busReq && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not one cycle after request");

  // Command path follows its pulse by exactly one cycle
  a_step_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmdPulse |=> motorCmdStep)
    else $error("Command step not forwarded");
  a_step_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cmdPulse |=> !motorCmdStep)
    else $error("Command step without a pulse");
  a_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wrTake && avs_address == OFS_DIR && avs_byteenable[0]) |=> dirStage_q == $past(avs_writedata[0]))
    else $error("Direction write not stored");
  a_pend_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    powerOnLoad |=> loadPending_q)
    else $error("Power-on load not taken");
  a_load_rest: assert property (@(posedge clk_sys) disable iff (!rst_n)
    loadPending_q |=> (modeActive_q == $past(modeStage_q) && divisorActive_q == $past(divisorStage_q)
      && cmdNumActive_q == $past(cmdNumStage_q) && cmdDenActive_q == $past(cmdDenStage_q)))
    else $error("Load did not copy mode or gear settings");
  a_hold_rest: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !loadPending_q |=> ($stable(modeActive_q) && $stable(cmdNumActive_q) && $stable(cmdDenActive_q)))
    else $error("Mode or gear changed without a load");
  a_div_numer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modeActive_q == MODE_DIVIDE |=> numer_q == 32'h1)
    else $error("Division numerator wrong");
  a_div_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (modeActive_q == MODE_DIVIDE && countActive_q == 16'h0) |=> denom_q == 32'h1)
    else $error("Zero division setting not taken as one");
  a_cmd_numer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (modeActive_q == MODE_CMD_UNIT && cmdDenActive_q != 16'h0) |=> numer_q[15:0] == $past(cmdDenActive_q))
    else $error("Command unit numerator wrong");
  a_cmd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (modeActive_q == MODE_CMD_UNIT && cmdNumActive_q == 16'h0) |=> denom_q == 32'h1)
    else $error("Zero command gear not taken as one");
  a_gear_numer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modeActive_q == MODE_GEAR |=> numer_q == {16'h0, $past(countActive_q)})
    else $error("Gear numerator wrong");
  a_read_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read && avs_waitrequest && avs_address == OFS_COUNT) |=> avs_readdata == {16'h0, $past(countStage_q)})
    else $error("Count read back wrong");

  // Position register mirrors every output edge
  a_fb_up: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (edgeBus.tick && edgeBus.up) |=> fbPos_q == $past(fbPos_q) + 32'h1)
    else $error("Position missed an up edge");
  a_fb_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (edgeBus.tick && !edgeBus.up) |=> fbPos_q == $past(fbPos_q) - 32'h1)
    else $error("Position missed a down edge");
  a_fb_still: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !edgeBus.tick |=> $stable(fbPos_q))
    else $error("Position moved without an edge");
endmodule

/* File: bench/quad_counter.sv */
// Host-side model: counts quadrature edges and A-phase pulses.
// Assumes A/B are registered on clk_sys, so one change per cycle at most.
`timescale 1ns/1ps
module quad_counter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic encA,
  input wire logic encB,
  output logic signed [31:0] edgeCount,
  output logic [31:0] aRises,
  output logic seqError
);
  logic [1:0] prevIdx;
  logic [1:0] curIdx;
  logic [1:0] move;
  logic prevA;
  // Gray position; A leads when moving up
  assign curIdx = {encA ^ encB ^ 1'b1, encA} == 2'b01 ? 2'h1 :
    {encA, encB} == 2'b11 ? 2'h2 : {encA, encB} == 2'b01 ? 2'h3 : 2'h0;
  assign move = curIdx - prevIdx;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prevIdx <= 2'h0;
      prevA <= 1'b0;
      edgeCount <= '0;
      aRises <= '0;
      seqError <= 1'b0;
    end else begin
      prevIdx <= curIdx;
      prevA <= encA;
      if (move == 2'h1) edgeCount <= edgeCount + 1;
      if (move == 2'h3) edgeCount <= edgeCount - 1;
      // Both phases jumping at once cannot be counted
      if (move == 2'h2) seqError <= 1'b1;
      if (encA && !prevA) aRises <= aRises + 1;
    end
  end
endmodule

/* File: bench/tb_encoder_pulse_output_gen.sv */
// Self-checking bench for the encoder feedback pulse generator.
// Assumes one wait cycle per bus request and the host model above.
`timescale 1ns/1ps
module tb_encoder_pulse_output_gen;
  import enc_out_pkg::*;
  typedef struct {string name; logic [31:0] val;} note_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic powerOnLoad = 1'b0;
  logic cmdPulse = 1'b0;
  logic cmdFwd = 1'b0;
  logic motorCmdStep;
  logic motorCmdCcw;
  logic motorStep = 1'b0;
  logic motorCcw = 1'b0;
  logic encOutA;
  logic encOutB;
  logic signed [31:0] edgeCount;
  logic [31:0] aRises;
  logic seqError;
  note_t rdQ[$];
  note_t cmdQ[$];
  int bad_count = 0;
  int checks = 0;
  int seed = 32'h7e17b841;
  int pos = 0;
  int rises = 0;

  encoder_pulse_output_gen dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .powerOnLoad(powerOnLoad), .cmdPulse(cmdPulse), .cmdFwd(cmdFwd), .motorCmdStep(motorCmdStep),
    .motorCmdCcw(motorCmdCcw), .motorStep(motorStep), .motorCcw(motorCcw), .encOutA(encOutA),
    .encOutB(encOutB));
  quad_counter host_u (.clk_sys(clk_sys), .rst_n(rst_n), .encA(encOutA), .encB(encOutB),
    .edgeCount(edgeCount), .aRises(aRises), .seqError(seqError));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= addr;
    avs_writedata <= data;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0);
    chk("waitCycles", 32'h2, n);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Upper lanes carry noise the registers must ignore
  task automatic wr(input logic [7:0] addr, input logic [15:0] val);
    logic [31:0] r;
    r = $random(seed);
    bus(1'b1, addr, {r[31:16], val});
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string name);
    rdQ.push_back('{name, exp});
    bus(1'b0, addr, 32'h0);
  endtask

  task automatic load();
    @(posedge clk_sys);
    powerOnLoad <= 1'b1;
    @(posedge clk_sys);
    powerOnLoad <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic cmd(input logic fwd, input logic ccw);
    cmdQ.push_back('{"motorCmdCcw", {31'h0, ccw}});
    @(posedge clk_sys);
    cmdPulse <= 1'b1;
    cmdFwd <= fwd;
    @(posedge clk_sys);
    cmdPulse <= 1'b0;
  endtask

  task automatic steps(input int n, input logic ccw, input int edges);
    repeat (n) begin
      @(posedge clk_sys);
      motorStep <= 1'b1;
      motorCcw <= ccw;
      @(posedge clk_sys);
      motorStep <= 1'b0;
      // Spacing keeps the edge rate within what the host counts
      repeat (2) @(posedge clk_sys);
    end
    repeat (12) @(posedge clk_sys);
    pos += edges;
    rises += (edges > 0 ? edges : -edges) / 4;
    chk("edgeCount", pos, edgeCount);
    chk("aRises", rises, aRises);
    rd(OFS_FB_POS, pos, "fbPos");
    $display("test steps %0d done", edges);
  endtask

  always @(posedge clk_sys) begin
    note_t n;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (rdQ.size() == 0) begin
        chk("readNote", 32'h1, 32'h0);
      end else begin
        n = rdQ.pop_front();
        chk(n.name, n.val, avs_readdata);
      end
    end
    if (motorCmdStep === 1'b1) begin
      if (cmdQ.size() == 0) begin
        chk("cmdNote", 32'h1, 32'h0);
      end else begin
        n = cmdQ.pop_front();
        chk(n.name, n.val, {31'h0, motorCmdCcw});
      end
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_DIR, 32'h0, "dir");
    rd(OFS_COUNT, 32'h0fa0, "count");
    rd(OFS_DIVISOR, 32'h1, "divisor");
    rd(OFS_MODE, 32'h0, "mode");
    rd(OFS_CMD_NUM, 32'h1, "cmdNum");
    rd(OFS_CMD_DEN, 32'h1, "cmdDen");
    rd(OFS_ACTIVE, 32'h0, "active");
    wr(8'h20, 16'h5a5a);
    rd(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    cmd(1'b1, 1'b1);
    cmd(1'b0, 1'b0);
    wr(OFS_DIR, 16'h1);
    wr(OFS_MODE, 16'h1);
    wr(OFS_COUNT, 16'h8);
    avs_byteenable <= 4'h2;
    wr(OFS_COUNT, 16'h1234);
    avs_byteenable <= 4'hf;
    rd(OFS_COUNT, 32'h1208, "countLane");
    wr(OFS_COUNT, 16'h8);
    rd(OFS_COUNT, 32'h8, "count");
    cmd(1'b1, 1'b1);
    rd(OFS_ACTIVE, 32'h0, "active");
    load();
    rd(OFS_ACTIVE, 32'h3, "active");
    cmd(1'b1, 1'b0);
    cmd(1'b0, 1'b1);
    $display("test direction done");
    steps(64, 1'b1, -8);
    wr(OFS_DIR, 16'h0);
    wr(OFS_MODE, 16'h3);
    wr(OFS_COUNT, 16'h3);
    wr(OFS_DIVISOR, 16'h0);
    load();
    rd(OFS_ACTIVE, 32'h6, "active");
    steps(4, 1'b1, 12);
    wr(OFS_DIVISOR, 16'h6);
    load();
    steps(8, 1'b1, 4);
    wr(OFS_MODE, 16'h0);
    wr(OFS_COUNT, 16'h8000);
    load();
    steps(64, 1'b1, 16);
    wr(OFS_MODE, 16'h2);
    wr(OFS_CMD_NUM, 16'h2);
    load();
    steps(32, 1'b0, -16);
    repeat (2) @(posedge clk_sys);
    chk("seqError", 32'h0, {31'h0, seqError});
    chk("pendingNotes", 32'h0, rdQ.size() + cmdQ.size());
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    test_done();
  end
endmodule
